//--- verilog/ltmc_top.sv
// limit timer start, stop and reset control with apb registers
//
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`include "ltmc_regs.svh"

module ltmc_top #(
    parameter int COUNT_WIDTH = 8,
    parameter int ADDR_WIDTH  = 12
) (
    // clock, reset, enable
    input  wire logic                   core_clk,
    input  wire logic                   reset_n,
    input  wire logic                   clk_en,
    // apb slave
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [ADDR_WIDTH-1:0]  paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    // trigger and debug
    input  wire logic                   external_trigger_input,
    input  wire logic                   debug_freeze,
    // timer outputs
    output logic                        postscaled_period_pulse,
    output logic                        period_irq,
    output logic      [COUNT_WIDTH-1:0] count_value
);

    // ======================================================
    // parameter checks
    if (COUNT_WIDTH < 2 || COUNT_WIDTH > 16) begin : g_chk_width
        $error("ltmc_top: COUNT_WIDTH must lie in 2..16");
    end
    if (ADDR_WIDTH < 5 || ADDR_WIDTH > 32) begin : g_chk_addr
        $error("ltmc_top: ADDR_WIDTH must lie in 5..32");
    end

    // ======================================================
    // state
    typedef struct packed {
        logic                     run;
        logic                     src_instr;
        logic [2:0]               prescale_select;
        logic [3:0]               postscale_select;
        ltmc_pkg::ltmc_mode_t     mode;
        logic [COUNT_WIDTH-1:0]   period_value;
        logic [COUNT_WIDTH-1:0]   count_value;
        logic [7:0]               pre_cnt;
        logic [3:0]               post_cnt;
        logic [1:0]               run_pipe;
        logic [1:0]               trig_pipe;
        logic                     trig_prev;
        ltmc_pkg::ltmc_phase_t    phase;
        logic                     pulse;
        logic                     irq_flag;
        logic                     irq_enable;
        logic                     irq_out;
        logic [31:0]              prdata;
        logic                     pready;
        logic                     pslverr;
    } ltmc_state_t;

    ltmc_state_t st;
    ltmc_state_t next_st;
    logic        trig_sync;

    // ======================================================
    // pin synchroniser
    ltmc_sync #(
        .WIDTH (1)
    ) u_trig_sync (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .clk_en   (clk_en),
        .async_in (external_trigger_input),
        .sync_out (trig_sync)
    );

    // ======================================================
    // next state
    always_comb begin
        logic [7:0]             pre_limit;
        logic                   tick;
        logic                   run_eff;
        logic                   trig_eff;
        logic                   lvl;
        logic                   rise;
        logic                   fall;
        logic                   edge_mode;
        logic                   one_shot;
        logic                   mono;
        logic                   reserved;
        logic                   go_lvl;
        logic                   hw_rst;
        logic                   start_ev;
        logic                   counting;
        logic                   armed;
        logic                   setup;
        logic                   access;
        logic                   hit;
        logic [11:0]            ofs;
        logic [31:0]            rd_word;
        logic                   flag_set;

        next_st   = st;
        pre_limit = 8'((16'h1 << st.prescale_select) - 16'h1);
        tick      = st.pre_cnt >= pre_limit;
        // instruction clock path is one tick shorter
        run_eff   = st.src_instr ? st.run_pipe[0]
                                 : st.run_pipe[1];
        trig_eff  = st.src_instr ? st.trig_pipe[0]
                                 : st.trig_pipe[1];
        // frozen: level held, so no edges are seen
        lvl       = debug_freeze ? st.trig_prev : trig_eff;
        rise      = lvl & !st.trig_prev;
        fall      = !lvl & st.trig_prev;
        armed     = st.phase == ltmc_pkg::LTMC_COUNTING;
        edge_mode = 1'b0;
        one_shot  = 1'b0;
        mono      = 1'b0;
        reserved  = 1'b0;
        go_lvl    = run_eff;
        hw_rst    = 1'b0;
        start_ev  = 1'b0;
        flag_set  = 1'b0;

        // --------------------------------------------------
        // mode decode: group in the top two bits
        case ({st.mode.group, st.mode.variant})
            5'h00: begin
            end
            5'h01: go_lvl = run_eff & lvl;
            5'h02: go_lvl = run_eff & !lvl;
            5'h03: hw_rst = rise | fall;
            5'h04: hw_rst = rise;
            5'h05: hw_rst = fall;
            5'h06: begin
                hw_rst = !lvl;
                go_lvl = run_eff & lvl;
            end
            5'h07: begin
                hw_rst = lvl;
                go_lvl = run_eff & !lvl;
            end
            5'h08: one_shot = 1'b1;
            5'h09, 5'h0a, 5'h0b: begin
                edge_mode = 1'b1;
                one_shot  = 1'b1;
                start_ev  = (st.mode.variant[0] & rise)
                          | (st.mode.variant[1] & fall);
            end
            5'h0c: begin
                edge_mode = 1'b1;
                one_shot  = 1'b1;
                start_ev  = rise;
                hw_rst    = rise & armed;
            end
            5'h0d: begin
                edge_mode = 1'b1;
                one_shot  = 1'b1;
                start_ev  = fall;
                hw_rst    = fall & armed;
            end
            5'h0e: begin
                edge_mode = 1'b1;
                one_shot  = 1'b1;
                start_ev  = rise;
                hw_rst    = !lvl;
            end
            5'h0f: begin
                edge_mode = 1'b1;
                one_shot  = 1'b1;
                start_ev  = fall;
                hw_rst    = lvl;
            end
            5'h11, 5'h12, 5'h13: begin
                edge_mode = 1'b1;
                mono      = 1'b1;
                start_ev  = (st.mode.variant[0] & rise)
                          | (st.mode.variant[1] & fall);
            end
            5'h16: begin
                one_shot = 1'b1;
                go_lvl   = run_eff & lvl;
                hw_rst   = !lvl;
            end
            5'h17: begin
                one_shot = 1'b1;
                go_lvl   = run_eff & !lvl;
                hw_rst   = lvl;
            end
            default: reserved = 1'b1;
        endcase

        counting = !reserved
                 & (edge_mode ? (run_eff & armed) : go_lvl);

        // --------------------------------------------------
        // timer tick
        if (tick) begin
            next_st.pre_cnt   = 8'h00;
        end else begin
            next_st.pre_cnt   = st.pre_cnt + 8'h01;
        end
        if (tick) begin
            next_st.run_pipe  = {st.run_pipe[0], st.run};
            next_st.trig_pipe = {st.trig_pipe[0], trig_sync};
            next_st.trig_prev = lvl;
            // one tick wide: cleared on the following tick
            next_st.pulse     = 1'b0;
            if (!run_eff) begin
                next_st.phase = ltmc_pkg::LTMC_WAIT_EDGE;
            end else if (edge_mode && !armed && start_ev) begin
                next_st.phase = ltmc_pkg::LTMC_COUNTING;
            end
            if (reserved) begin
                next_st.count_value = st.count_value;
            end else if (hw_rst) begin
                next_st.count_value = '0;
                next_st.post_cnt    = 4'h0;
                next_st.pre_cnt     = 8'h00;
            end else if (counting) begin
                if (st.count_value == st.period_value) begin
                    next_st.count_value = '0;
                    if (st.post_cnt == st.postscale_select) begin
                        next_st.post_cnt = 4'h0;
                        next_st.pulse    = 1'b1;
                        flag_set         = 1'b1;
                    end else begin
                        next_st.post_cnt = st.post_cnt + 4'h1;
                    end
                    if (one_shot) begin
                        next_st.run      = 1'b0;
                        next_st.run_pipe = 2'b00;
                        next_st.phase    = ltmc_pkg::LTMC_WAIT_EDGE;
                    end
                    if (mono) begin
                        next_st.phase    = ltmc_pkg::LTMC_WAIT_EDGE;
                    end
                end else begin
                    next_st.count_value = st.count_value + 1'b1;
                end
            end
        end

        // --------------------------------------------------
        // apb slave: one wait state, answer on second access cycle
        setup  = psel & penable & !st.pready;
        access = psel & penable & st.pready;
        ofs    = 12'(paddr);
        hit    = paddr[1:0] == 2'b00
               && (ofs == `LTMC_OFS_CONTROL || ofs == `LTMC_OFS_LIMIT
               ||  ofs == `LTMC_OFS_PERIOD  || ofs == `LTMC_OFS_COUNT
               ||  ofs == `LTMC_OFS_IRQ)
               && (ADDR_WIDTH <= 12 || (paddr >> 12) == '0);
        rd_word = 32'h0000_0000;
        case (ofs)
            `LTMC_OFS_CONTROL: begin
                rd_word[`LTMC_CTL_RUN]       = st.run;
                rd_word[`LTMC_CTL_SRC_INSTR] = st.src_instr;
                rd_word[`LTMC_CTL_PRE_MSB:`LTMC_CTL_PRE_LSB] =
                    st.prescale_select;
                rd_word[`LTMC_CTL_POST_MSB:`LTMC_CTL_POST_LSB] =
                    st.postscale_select;
            end
            `LTMC_OFS_LIMIT:
                rd_word[`LTMC_LIM_MODE_MSB:`LTMC_LIM_MODE_LSB] = st.mode;
            `LTMC_OFS_PERIOD:
                rd_word[COUNT_WIDTH-1:0] = st.period_value;
            `LTMC_OFS_COUNT:
                rd_word[COUNT_WIDTH-1:0] = st.count_value;
            `LTMC_OFS_IRQ: begin
                rd_word[`LTMC_IRQ_FLAG]   = st.irq_flag;
                rd_word[`LTMC_IRQ_ENABLE] = st.irq_enable;
            end
            default: rd_word = 32'h0000_0000;
        endcase
        next_st.pready  = setup;
        next_st.pslverr = setup & !hit;
        if (setup) begin
            next_st.prdata = (hit && !pwrite) ? rd_word : 32'h0000_0000;
        end

        // writes take effect at the edge that sees pready
        if (access && pwrite && hit) begin
            case (ofs)
                `LTMC_OFS_CONTROL: begin
                    next_st.run       = pwdata[`LTMC_CTL_RUN];
                    next_st.src_instr = pwdata[`LTMC_CTL_SRC_INSTR];
                    next_st.prescale_select =
                        pwdata[`LTMC_CTL_PRE_MSB:`LTMC_CTL_PRE_LSB];
                    next_st.postscale_select =
                        pwdata[`LTMC_CTL_POST_MSB:`LTMC_CTL_POST_LSB];
                    // count itself is kept on a control write
                    next_st.pre_cnt  = 8'h00;
                    next_st.post_cnt = 4'h0;
                end
                `LTMC_OFS_LIMIT:
                    next_st.mode =
                        pwdata[`LTMC_LIM_MODE_MSB:`LTMC_LIM_MODE_LSB];
                `LTMC_OFS_PERIOD:
                    next_st.period_value = pwdata[COUNT_WIDTH-1:0];
                `LTMC_OFS_COUNT: begin
                    next_st.count_value = pwdata[COUNT_WIDTH-1:0];
                    next_st.pre_cnt     = 8'h00;
                    next_st.post_cnt    = 4'h0;
                end
                `LTMC_OFS_IRQ: begin
                    next_st.irq_enable = pwdata[`LTMC_IRQ_ENABLE];
                    if (pwdata[`LTMC_IRQ_FLAG]) begin
                        next_st.irq_flag = 1'b0;
                    end
                end
                default: next_st.mode = st.mode;
            endcase
        end

        // set after clear, so a period event is never lost
        if (flag_set) begin
            next_st.irq_flag = 1'b1;
        end
        next_st.irq_out = next_st.irq_flag & next_st.irq_enable;
    end

    // ======================================================
    // state register
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            st                  <= '0;
            st.period_value     <= COUNT_WIDTH'(`LTMC_RST_PERIOD);
            st.count_value      <= COUNT_WIDTH'(`LTMC_RST_COUNT);
            st.mode             <= `LTMC_RST_MODE;
            st.prescale_select  <= `LTMC_RST_PRESCALE;
            st.postscale_select <= `LTMC_RST_POSTSCALE;
            st.phase            <= ltmc_pkg::LTMC_WAIT_EDGE;
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    // ======================================================
    // outputs
    assign prdata                  = st.prdata;
    assign pready                  = st.pready;
    assign pslverr                 = st.pslverr;
    assign postscaled_period_pulse = st.pulse;
    assign period_irq              = st.irq_out;
    assign count_value             = st.count_value;

endmodule : ltmc_top

//--- verilog/ltmc_regs.svh
// register offsets, field positions, reset values and sync depths
`ifndef LTMC_REGS_SVH
`define LTMC_REGS_SVH

// ==========================================================
// register byte offsets
`define LTMC_OFS_CONTROL     12'h000
`define LTMC_OFS_LIMIT       12'h004
`define LTMC_OFS_PERIOD      12'h008
`define LTMC_OFS_COUNT       12'h00c
`define LTMC_OFS_IRQ         12'h010

// ==========================================================
// control register fields
`define LTMC_CTL_RUN         0
`define LTMC_CTL_SRC_INSTR   1
`define LTMC_CTL_PRE_LSB     2
`define LTMC_CTL_PRE_MSB     4
`define LTMC_CTL_POST_LSB    8
`define LTMC_CTL_POST_MSB    11

// ==========================================================
// limit, irq fields
`define LTMC_LIM_MODE_LSB    0
`define LTMC_LIM_MODE_MSB    4
`define LTMC_IRQ_FLAG        0
`define LTMC_IRQ_ENABLE      1

// ==========================================================
// reset values
`define LTMC_RST_PERIOD      8'hff
`define LTMC_RST_COUNT       8'h00
`define LTMC_RST_MODE        5'h00
`define LTMC_RST_PRESCALE    3'h0
`define LTMC_RST_POSTSCALE   4'h0

// ==========================================================
// synchronisation depth in timer ticks
`define LTMC_SYNC_TICKS_OTHER 2
`define LTMC_SYNC_TICKS_INSTR 1

`endif

//--- verilog/ltmc_pkg.sv
// types shared by the limit timer files
package ltmc_pkg;

    // ======================================================
    // start phase of edge-started modes
    typedef enum logic {
        LTMC_WAIT_EDGE,
        LTMC_COUNTING
    } ltmc_phase_t;

    // ======================================================
    // mode field split into group and variant
    typedef struct packed {
        logic [1:0] group;
        logic [2:0] variant;
    } ltmc_mode_t;

endpackage : ltmc_pkg

//--- verilog/ltmc_sync.sv
// two flip-flop level synchroniser for pin inputs
module ltmc_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             reset_n,
    input  wire logic             clk_en,
    // data
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    // ======================================================
    // state
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } ltmc_sync_state_t;

    ltmc_sync_state_t st;
    ltmc_sync_state_t next_st;

    if (WIDTH < 1) begin : g_check
        $error("ltmc_sync: WIDTH must be at least 1");
    end

    always_comb begin
        next_st        = st;
        next_st.stage1 = async_in;
        // stage1 is read only by stage2
        next_st.stage2 = st.stage1;
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            st <= '0;
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    assign sync_out = st.stage2;

endmodule : ltmc_sync

//--- bench/ltmc_asserts.sv
// port-level assertions for the limit timer top
module ltmc_asserts #(
    parameter int COUNT_WIDTH = 8,
    parameter int ADDR_WIDTH  = 12
) (
    // clock and reset
    input wire logic                   core_clk,
    input wire logic                   reset_n,
    // apb
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [ADDR_WIDTH-1:0]  paddr,
    input wire logic [31:0]            prdata,
    input wire logic                   pready,
    input wire logic                   pslverr,
    // timer
    input wire logic                   postscaled_period_pulse,
    input wire logic                   period_irq,
    input wire logic [COUNT_WIDTH-1:0] count_value
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    logic irq_wr;
    logic cnt_wr;
    logic mapped;
    assign irq_wr = psel && penable && pready && pwrite && paddr == 12'h010;
    assign cnt_wr = psel && penable && pready && pwrite && paddr == 12'h00c;
    assign mapped = paddr inside {12'h000, 12'h004, 12'h008, 12'h00c,
                                  12'h010};

    a_ready_wait: assert property (psel && !penable |-> ##2 pready)
        else $error("pready missing after one wait state");
    a_ready_single: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_unmapped: assert property (pready |-> pslverr == !mapped)
        else $error("pslverr does not match the address");
    a_err_no_data: assert property (pslverr |-> prdata == 32'h0)
        else $error("read data not zero on error");
    a_pulse_at_zero: assert property (
        postscaled_period_pulse |-> count_value == '0)
        else $error("period pulse with nonzero count");
    a_count_steps: assert property (
        $changed(count_value) |-> count_value == '0 ||
        count_value == $past(count_value) + 1'b1 ||
        $past(cnt_wr) || $past(cnt_wr, 2))
        else $error("count moved other than up or to zero");
    a_irq_rise_cause: assert property (
        $rose(period_irq) |-> postscaled_period_pulse || $past(irq_wr))
        else $error("interrupt rose without pulse or enable");
    a_irq_fall_cause: assert property (
        $fell(period_irq) |-> $past(irq_wr))
        else $error("interrupt fell without software write");

    c_irq: cover property ($rose(period_irq));
endmodule : ltmc_asserts

bind ltmc_top ltmc_asserts #(
    .COUNT_WIDTH(COUNT_WIDTH),
    .ADDR_WIDTH (ADDR_WIDTH)
) u_asserts (
    .core_clk               (core_clk),
    .reset_n                (reset_n),
    .psel                   (psel),
    .penable                (penable),
    .pwrite                 (pwrite),
    .paddr                  (paddr),
    .prdata                 (prdata),
    .pready                 (pready),
    .pslverr                (pslverr),
    .postscaled_period_pulse(postscaled_period_pulse),
    .period_irq             (period_irq),
    .count_value            (count_value)
);

//--- bench/ltmc_trig_model.sv
// on-chip trigger source feeding the external trigger input
module ltmc_trig_model (
    input  wire logic core_clk,
    input  wire logic reset_n,
    input  wire logic want,
    output logic      trig
);
    timeunit 1ns;
    timeprecision 1ns;
    int gap;
    // a change waits until six ticks have passed since the last one,
    // which also keeps every level for at least seven ticks
    always @(posedge core_clk) begin
        if (!reset_n) begin
            trig <= 1'b0;
            gap  <= 0;
        end else if (want != trig && gap >= 6) begin
            trig <= want;
            gap  <= 0;
        end else begin
            gap <= gap + 1;
        end
    end
endmodule : ltmc_trig_model

//--- bench/test_limit_timer_mode_control.sv
// self-checking bench for the limit timer mode control
module test_limit_timer_mode_control;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 0, reset_n = 0, clk_en = 1;
    logic psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, r;
    logic trig, want = 0, debug_freeze = 0, pulse, irq, e;
    logic [7:0] count;
    logic [4:0] mode;
    int err_total = 0, cmp_count = 0, seed = 23, cyc = 0, pcnt, t0;
    int p, q, src;

    ltmc_top u_dut (.core_clk(core_clk), .reset_n(reset_n),
        .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .external_trigger_input(trig),
        .debug_freeze(debug_freeze), .postscaled_period_pulse(pulse),
        .period_irq(irq), .count_value(count));
    ltmc_trig_model u_trig (.core_clk(core_clk), .reset_n(reset_n),
        .want(want), .trig(trig));

    initial forever #50 core_clk = ~core_clk;
    always @(posedge core_clk) cyc <= cyc + 1;
    always @(posedge core_clk) if (pulse === 1'b1) pcnt <= pcnt + 1;

    task end_sim;
        $display("checks %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_sim

    task chk(input string what, input logic [31:0] x, input logic [31:0] g);
        cmp_count++;
        if (g !== x) begin
            $display("[FAIL] %s expected %h seen %h", what, x, g);
            err_total++;
        end
    endtask : chk

    // ==========================================================
    // apb master: hold everything until pready is sampled
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge core_clk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge core_clk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
        if (n >= 20) begin
            chk("apb timeout", 0, 1);
            end_sim();
        end
    endtask : apb

    task idle(input int n);
        repeat (n) @(posedge core_clk);
    endtask : idle

    // waits for a fresh rising pulse, bounded
    task wait_pulse;
        int n;
        n = 0;
        while (pulse === 1'b1 && n < 300) begin idle(1); n++; end
        while (pulse !== 1'b1 && n < 300) begin idle(1); n++; end
        if (n >= 300) begin
            chk("pulse timeout", 0, 1);
            end_sim();
        end
        t0 = cyc;
    endtask : wait_pulse

    task prep(input logic [4:0] m, input logic [7:0] per, input logic lv);
        apb(1, 12'h000, 0);
        apb(1, 12'h004, m);
        apb(1, 12'h008, per);
        want <= lv;
        idle(12);
        apb(1, 12'h00c, 0);
        pcnt = 0;
    endtask : prep

    initial begin
        idle(12);
        reset_n <= 1;
        // ======================================================
        // reset values and an unmapped address
        apb(0, 12'h008, 0); chk("period rst", 32'hff, r);
        apb(0, 12'h000, 0); chk("ctrl rst", 0, r);
        apb(0, 12'h004, 0); chk("mode rst", 0, r);
        apb(0, 12'h014, 0); chk("unmapped err", 1, e);
        $display("test reset done");
        // ======================================================
        // edge-started one-shot and monostable
        for (int i = 0; i < 6; i++) begin
            src = $random(seed) & 1;
            mode = {(i < 3) ? 2'b01 : 2'b10, 3'(i % 3 + 1)};
            prep(mode, 8'h03, mode[2:0] == 3'h2);
            apb(1, 12'h000, 1 | src << 1);
            idle(15); chk("no edge idle", 0, count);
            chk("no edge pulses", 0, pcnt);
            want <= !want;
            wait_pulse; idle(3);
            chk("halt zero", 0, count);
            apb(0, 12'h000, 0);
            chk("run after", mode[4], r[0]);
            apb(1, 12'h000, 0); apb(1, 12'h000, 1 | src << 1);
            idle(15); chk("no resume", 0, count);
            chk("no resume pulses", 1, pcnt);
        end
        $display("test edge start done");
        // edge start with same-edge reset
        for (int i = 4; i < 6; i++) begin
            prep(5'(8 + i), 8'hc8, i == 5);
            apb(1, 12'h000, 1);
            want <= i != 5; idle(25);
            want <= i == 5; idle(12);
            want <= i != 5; idle(9);
            chk("edge reset", 1, count < 8'd14);
        end
        $display("test edge reset done");
        // edge or level start, level reset
        for (int k = 0; k < 4; k++) begin
            mode = (k < 2) ? 5'(14 + k) : 5'(20 + k);
            prep(mode, 8'hc8, mode[0]);
            apb(1, 12'h000, 1);
            want <= !mode[0]; idle(20);
            chk("level run", 1, count > 0);
            want <= mode[0]; idle(12);
            chk("level held", 0, count);
        end
        $display("test level done");
        // reserved codes and debug freeze
        for (int k = 0; k < 5; k++) begin
            mode = (k == 0) ? 5'h10 : (k < 3) ? 5'(19 + k)
                 : (k == 3) ? 5'h18 : 5'h1f;
            prep(mode, 8'h02, 0);
            apb(1, 12'h000, 1);
            want <= 1; idle(12); want <= 0; idle(12);
            chk("reserved count", 0, count);
            chk("reserved pulses", 0, pcnt);
        end
        prep(5'h09, 8'h02, 0);
        debug_freeze <= 1;
        apb(1, 12'h000, 1);
        want <= 1; idle(30);
        chk("frozen trigger", 0, count);
        chk("frozen pulses", 0, pcnt);
        debug_freeze <= 0;
        // software-started one-shot: one period, then run drops
        prep(5'h08, 8'h03, 0);
        apb(1, 12'h000, 1); idle(15);
        chk("sw one-shot pulses", 1, pcnt);
        apb(0, 12'h000, 0); chk("sw one-shot run", 0, r[0]);
        $display("test reserved freeze done");
        // ======================================================
        // postscaler spacing, random and corner ratios
        for (int i = 0; i < 6; i++) begin
            p = (i == 0) ? 1 : (i == 1) ? 5 : 1 + ($random(seed) & 7);
            q = (i == 0) ? 0 : (i == 1) ? 15 : $random(seed) & 15;
            prep(5'h00, 8'(p), 0);
            // clear the flag, enable the interrupt on odd passes only
            apb(1, 12'h010, 1 | (i & 1) << 1);
            apb(1, 12'h000, 1 | q << 8);
            wait_pulse; src = t0; wait_pulse;
            chk("pulse gap", (p + 1) * (q + 1), t0 - src);
            chk("irq gate", i & 1, irq);
        end
        apb(1, 12'h000, 0); idle(5);
        apb(0, 12'h010, 0); chk("flag sticky", 3, r);
        apb(1, 12'h010, 3); idle(2);
        chk("irq cleared", 0, irq);
        $display("test postscale done");
        end_sim();
    end
endmodule : test_limit_timer_mode_control
